//--- hw/rcs_consts.svh
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// Bus clock period and the printed waits.
`define RCS_BUS_PERIOD_NS   25
`define RCS_RESET_MIN_MS    1
`define RCS_NS_PER_MS       1000000
`define RCS_RESET_CYCLES    ((`RCS_RESET_MIN_MS * `RCS_NS_PER_MS + `RCS_BUS_PERIOD_NS - 1) / `RCS_BUS_PERIOD_NS)
`define RCS_PG_LOW_CYCLES   10
`define RCS_CFG_SETUP       4
`define RCS_HOLD_MIN        2
`define RCS_HOLD_MAX        20
`define RCS_HOLD_DEFAULT    10
`define RCS_SAFE_DELAY      5
`define RCS_PULSE_MIN       2

// Widths.
`define RCS_CNT_W           16
`define RCS_CFG_W           15
`define RCS_RATIO_W         4
`define RCS_MULT_W          3

// Clock-ratio strap codes and core multipliers.
`define RCS_RATIO_X4        4'h0
`define RCS_RATIO_X5        4'h1
`define RCS_MULT_X4         3'h4
`define RCS_MULT_X5         3'h5

`endif

//--- hw/rcs_pkg.sv
`include "rcs_consts.svh"

package rcs_pkg;

  typedef logic [`RCS_CFG_W-1:0]   cfg_t;
  typedef logic [`RCS_RATIO_W-1:0] ratio_t;
  typedef logic [`RCS_CNT_W-1:0]   cnt_t;

  typedef enum logic [2:0] {
    S_OFF,
    S_PGLOW,
    S_RESET,
    S_RELEASE,
    S_RUN
  } sys_state_t;

endpackage : rcs_pkg

//--- hw/rcs_if.sv
`timescale 1ns/1ps
`include "rcs_consts.svh"

interface rcs_if;
  logic                    powerOk;
  logic                    hardReset_n;
  logic [`RCS_CFG_W-1:0]   cfgOut;
  logic                    cfgOe;
  logic [`RCS_RATIO_W-1:0] ratioOut;
  logic                    ratioOe;
  logic [`RCS_CFG_W-1:0]   cfgPin;
  logic [`RCS_RATIO_W-1:0] ratioPin;
  logic                    coreReady;

  // Strap pins read low once the system side hands them back to normal use.
  assign cfgPin   = cfgOe ? cfgOut : '0;
  assign ratioPin = ratioOe ? ratioOut : '0;

  modport sysEnd (
    output powerOk,
    output hardReset_n,
    output cfgOut,
    output cfgOe,
    output ratioOut,
    output ratioOe,
    input  coreReady
  );

  modport devEnd (
    input  powerOk,
    input  hardReset_n,
    input  cfgPin,
    input  ratioPin,
    output coreReady
  );
endinterface : rcs_if

//--- hw/rcs_device.sv
`timescale 1ns/1ps
`include "rcs_consts.svh"

module rcs_device
  import rcs_pkg::*;
#(
  parameter int RST_CYCLES     = `RCS_RESET_CYCLES,
  parameter bit FAST_CLK_START = 1'b0
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // Link
  rcs_if.devEnd                       link,
  // User side
  output logic [`RCS_MULT_W-1:0]      coreMult,
  output cfg_t                        cfgStraps,
  output logic                        running,
  output logic                        ratioErr,
  output logic                        powerLowShort,
  output logic                        resetShort,
  output logic                        pulseShort
);

  localparam int   IW      = 2 + `RCS_CFG_W + `RCS_RATIO_W;
  localparam cnt_t RST_LIM = cnt_t'(RST_CYCLES);
  localparam cnt_t LOW_LIM = cnt_t'(`RCS_PG_LOW_CYCLES);
  localparam cnt_t PW_LIM  = cnt_t'(`RCS_PULSE_MIN);

  logic [IW-1:0] pin1_reg;
  logic [IW-1:0] pin2_reg;
  logic          pgS;
  logic          rstS;
  cfg_t          cfgS;
  ratio_t        ratS;

  // Every link pin passes two flops on rising mclk before any logic reads it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin1_reg <= '0;
      pin2_reg <= '0;
    end else begin
      pin1_reg <= {link.powerOk, link.hardReset_n, link.cfgPin, link.ratioPin}; // RULE14
      pin2_reg <= pin1_reg;
    end
  end

  assign pgS  = pin2_reg[IW-1];
  assign rstS = pin2_reg[IW-2];
  assign cfgS = pin2_reg[`RCS_RATIO_W +: `RCS_CFG_W];
  assign ratS = pin2_reg[`RCS_RATIO_W-1:0];

  logic                  rstPrev_reg, rstPrev_next;
  logic                  pgPrev_reg, pgPrev_next;
  cfg_t                  cfg_reg, cfg_next;
  logic [`RCS_MULT_W-1:0] mult_reg, mult_next;
  logic                  run_reg, run_next;
  logic                  ratioErr_reg, ratioErr_next;
  logic                  pgLow_reg, pgLow_next;
  logic                  rstShort_reg, rstShort_next;
  logic                  pulse_reg, pulse_next;
  logic                  ready_reg, ready_next;
  cnt_t                  lowCnt_reg, lowCnt_next;
  cnt_t                  rstCnt_reg, rstCnt_next;
  cnt_t                  widthCnt_reg, widthCnt_next;
  cnt_t                  holdCnt_reg, holdCnt_next;

  always_comb begin
    rstPrev_next  = rstS;
    pgPrev_next   = pgS;
    cfg_next      = cfg_reg;
    mult_next     = mult_reg;
    run_next      = run_reg;
    ratioErr_next = ratioErr_reg;
    pgLow_next    = pgLow_reg;
    rstShort_next = rstShort_reg;
    pulse_next    = pulse_reg;
    ready_next    = ready_reg;
    lowCnt_next   = lowCnt_reg;
    rstCnt_next   = rstCnt_reg;
    widthCnt_next = widthCnt_reg;
    holdCnt_next  = holdCnt_reg;
    // Power-good low time, checked at its rising edge.
    if (!pgS) begin
      if (lowCnt_reg != LOW_LIM) lowCnt_next = lowCnt_reg + 1'b1;
    end else begin
      lowCnt_next = '0;
    end
    if (pgS && !pgPrev_reg && !FAST_CLK_START && lowCnt_reg < LOW_LIM) begin
      pgLow_next = 1'b1; // RULE3 RULE4
    end
    // Reset low time counted from power-good high.
    if (!pgS || rstS) begin
      rstCnt_next = '0;
    end else if (rstCnt_reg != RST_LIM) begin
      rstCnt_next = rstCnt_reg + 1'b1;
    end
    // Reset level width on the hard reset pin.
    if (rstS != rstPrev_reg) begin
      widthCnt_next = cnt_t'(1);
      if (widthCnt_reg < PW_LIM) pulse_next = 1'b1; // RULE12
    end else if (widthCnt_reg != PW_LIM) begin
      widthCnt_next = widthCnt_reg + 1'b1;
    end
    // Assertion may come at any edge and only clears run; the sampled release latches straps and ratio.
    if (!rstS) begin
      run_next = 1'b0; // RULE2
    end else if (!rstPrev_reg) begin
      run_next = 1'b1;
      cfg_next = cfgS; // RULE15
      if (rstCnt_reg < RST_LIM) rstShort_next = 1'b1; // RULE1 RULE10
      case (ratS)
        `RCS_RATIO_X4: begin
          mult_next     = `RCS_MULT_X4; // RULE11
          ratioErr_next = 1'b0;
        end
        `RCS_RATIO_X5: begin
          mult_next     = `RCS_MULT_X5; // RULE11
          ratioErr_next = 1'b0;
        end
        default: begin
          mult_next     = `RCS_MULT_X4;
          ratioErr_next = 1'b1;
        end
      endcase
    end
    // Ready pin follows run state but never changes twice within two clocks.
    if (ready_reg != run_reg && holdCnt_reg >= PW_LIM) begin
      ready_next   = run_reg; // RULE13
      holdCnt_next = cnt_t'(1);
    end else if (holdCnt_reg != PW_LIM) begin
      holdCnt_next = holdCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPrev_reg  <= 1'b0;
      pgPrev_reg   <= 1'b0;
      cfg_reg      <= '0;
      mult_reg     <= `RCS_MULT_X4;
      run_reg      <= 1'b0;
      ratioErr_reg <= 1'b0;
      pgLow_reg    <= 1'b0;
      rstShort_reg <= 1'b0;
      pulse_reg    <= 1'b0;
      ready_reg    <= 1'b0;
      lowCnt_reg   <= '0;
      rstCnt_reg   <= '0;
      widthCnt_reg <= cnt_t'(`RCS_PULSE_MIN);
      holdCnt_reg  <= cnt_t'(`RCS_PULSE_MIN);
    end else begin
      rstPrev_reg  <= rstPrev_next;
      pgPrev_reg   <= pgPrev_next;
      cfg_reg      <= cfg_next;
      mult_reg     <= mult_next;
      run_reg      <= run_next;
      ratioErr_reg <= ratioErr_next;
      pgLow_reg    <= pgLow_next;
      rstShort_reg <= rstShort_next;
      pulse_reg    <= pulse_next;
      ready_reg    <= ready_next;
      lowCnt_reg   <= lowCnt_next;
      rstCnt_reg   <= rstCnt_next;
      widthCnt_reg <= widthCnt_next;
      holdCnt_reg  <= holdCnt_next;
    end
  end

  assign link.coreReady = ready_reg;
  assign coreMult       = mult_reg;
  assign cfgStraps      = cfg_reg;
  assign running        = run_reg;
  assign ratioErr       = ratioErr_reg;
  assign powerLowShort  = pgLow_reg;
  assign resetShort     = rstShort_reg;
  assign pulseShort     = pulse_reg;

endmodule : rcs_device

//--- hw/rcs_system.sv
// Contract
// RULE1: Hold reset 1 ms after power-good.
// RULE2: Reset asserts anytime, releases on clock edge.
// RULE3: Power-good low at least 10 clocks.
// RULE4: Fast-starting clock waives the 10-clock wait.
// RULE5: First strap group set 4 clocks before release.
// RULE6: First strap group held 2 to 20 clocks.
// RULE7: Ratio straps set 1 ms before release.
// RULE8: Safe ratio within 5 clocks of reset.
// RULE9: Ratio straps held 2 to 20 clocks.
// RULE10: Release only 1 ms after power-good.
// RULE11: Core runs at bus clock times 4 or 5.
// RULE12: Inputs stay each level at least 2 clocks. Only the reset pin is guarded; power-good can be high one clock on supply loss.
// RULE13: Device outputs hold each level 2 clocks.
// RULE14: Everything timed on rising bus clock edges.
// RULE15: Straps latched at release, ignored until reset.
`timescale 1ns/1ps
`include "rcs_consts.svh"

module rcs_system
  import rcs_pkg::*;
#(
  parameter int RST_CYCLES     = `RCS_RESET_CYCLES,
  parameter int HOLD_CYCLES    = `RCS_HOLD_DEFAULT,
  parameter bit FAST_CLK_START = 1'b0
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Link
  rcs_if.sysEnd     link,
  // User side
  input  wire logic supplyOk,
  input  wire logic warmReq,
  input  wire cfg_t cfgValue,
  input  wire logic ratioFive,
  output logic      inReset,
  output logic      running,
  output logic      coreReadySeen
);

  localparam cnt_t RST_LIM  = cnt_t'(RST_CYCLES);
  localparam cnt_t HOLD_LIM = cnt_t'(HOLD_CYCLES);
  localparam cnt_t LOW_LIM  = FAST_CLK_START ? cnt_t'(1) : cnt_t'(`RCS_PG_LOW_CYCLES);

  sys_state_t state_reg, state_next;
  cnt_t       cnt_reg, cnt_next;
  logic       pg_reg, pg_next;
  logic       rstN_reg, rstN_next;
  logic       cfgOe_reg, cfgOe_next;
  logic       ratioOe_reg, ratioOe_next;
  cfg_t       cfgOut_reg, cfgOut_next;
  ratio_t     ratioOut_reg, ratioOut_next;
  logic       run_reg, run_next;
  logic       ready_reg, ready_next;
  ratio_t     ratioCode;
  logic       inReset_reg, inReset_next;
  logic       supplyMeta_reg;
  logic       supplySync_reg;
  logic       warmMeta_reg;
  logic       warmSync_reg;

  // The ratio driven during reset is always the final one, which is safe.
  assign ratioCode = ratioFive ? `RCS_RATIO_X5 : `RCS_RATIO_X4;

  // Supply-good and the warm request are asynchronous, so each passes two flops first.
  // A warm request must therefore stand for at least one full clock.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      supplyMeta_reg <= 1'b0;
      supplySync_reg <= 1'b0;
      warmMeta_reg   <= 1'b0;
      warmSync_reg   <= 1'b0;
    end else begin
      supplyMeta_reg <= supplyOk;
      supplySync_reg <= supplyMeta_reg;
      warmMeta_reg   <= warmReq;
      warmSync_reg   <= warmMeta_reg;
    end
  end

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    pg_next       = pg_reg;
    rstN_next     = rstN_reg;
    cfgOe_next    = cfgOe_reg;
    ratioOe_next  = ratioOe_reg;
    cfgOut_next   = cfgOut_reg;
    ratioOut_next = ratioOut_reg;
    run_next      = run_reg;
    ready_next    = link.coreReady;
    case (state_reg)
      S_OFF: begin
        pg_next      = 1'b0;
        rstN_next    = 1'b0;
        cfgOe_next   = 1'b0;
        ratioOe_next = 1'b0;
        run_next     = 1'b0;
        if (supplySync_reg) begin
          state_next = S_PGLOW;
          cnt_next   = '0;
        end
      end
      S_PGLOW: begin
        // Straps go out while power-good is still low.
        cfgOe_next    = 1'b1;
        ratioOe_next  = 1'b1;
        cfgOut_next   = cfgValue;
        ratioOut_next = ratioCode;
        if (cnt_reg >= LOW_LIM - 1'b1) begin
          state_next = S_RESET; // RULE3 RULE4
          pg_next    = 1'b1;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      S_RESET: begin
        // Reset stays low for the full wait after power-good, which also
        // covers both strap setup times since the straps are already out.
        if (cnt_reg >= RST_LIM - 1'b1) begin
          state_next = S_RELEASE;
          rstN_next  = 1'b1; // RULE1 RULE10 RULE5 RULE7 RULE2
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      S_RELEASE: begin
        if (cnt_reg >= HOLD_LIM - 1'b1) begin
          state_next   = S_RUN;
          cfgOe_next   = 1'b0; // RULE6
          ratioOe_next = 1'b0; // RULE9
          run_next     = 1'b1;
          cnt_next     = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      S_RUN: begin
        if (warmSync_reg) begin
          // Reset and a safe ratio go out on the same edge.
          state_next    = S_RESET;
          rstN_next     = 1'b0;
          cfgOe_next    = 1'b1;
          ratioOe_next  = 1'b1; // RULE8
          cfgOut_next   = cfgValue;
          ratioOut_next = ratioCode; // RULE8
          run_next      = 1'b0;
          cnt_next      = '0;
        end
      end
      default: begin
        state_next = S_OFF;
      end
    endcase
    // Supply loss drops everything, except right after a release so the
    // reset pin never shows a one-clock high level.
    if (!supplySync_reg && state_reg != S_OFF &&
        !(state_reg == S_RELEASE && cnt_reg == '0)) begin // RULE12
      state_next   = S_OFF;
      pg_next      = 1'b0;
      rstN_next    = 1'b0; // RULE2
      cfgOe_next   = 1'b0;
      ratioOe_next = 1'b0;
      run_next     = 1'b0;
      cnt_next     = '0;
    end
    inReset_next = ~rstN_next;
  end

  // All link outputs change on rising mclk only.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= S_OFF;
      cnt_reg      <= '0;
      pg_reg       <= 1'b0;
      rstN_reg     <= 1'b0;
      cfgOe_reg    <= 1'b0;
      ratioOe_reg  <= 1'b0;
      cfgOut_reg   <= '0;
      ratioOut_reg <= `RCS_RATIO_X4;
      run_reg      <= 1'b0;
      ready_reg    <= 1'b0;
      inReset_reg  <= 1'b1;
    end else begin
      state_reg    <= state_next; // RULE14
      cnt_reg      <= cnt_next;
      pg_reg       <= pg_next;
      rstN_reg     <= rstN_next;
      cfgOe_reg    <= cfgOe_next;
      ratioOe_reg  <= ratioOe_next;
      cfgOut_reg   <= cfgOut_next;
      ratioOut_reg <= ratioOut_next;
      run_reg      <= run_next;
      ready_reg    <= ready_next;
      inReset_reg  <= inReset_next;
    end
  end

  assign link.powerOk     = pg_reg;
  assign link.hardReset_n = rstN_reg;
  assign link.cfgOut      = cfgOut_reg;
  assign link.cfgOe       = cfgOe_reg;
  assign link.ratioOut    = ratioOut_reg;
  assign link.ratioOe     = ratioOe_reg;
  assign inReset          = inReset_reg;
  assign running          = run_reg;
  assign coreReadySeen    = ready_reg;

endmodule : rcs_system

//--- tb/reset_config_sequencer_sva.sv
`timescale 1ns/1ps
`include "rcs_consts.svh"

module reset_config_sequencer_sva #(
  parameter int RST_CYCLES = `RCS_RESET_CYCLES
) (
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    rst_n,
  // Link
  input wire logic                    powerOk,
  input wire logic                    hardReset_n,
  input wire logic [`RCS_CFG_W-1:0]   cfgOut,
  input wire logic                    cfgOe,
  input wire logic [`RCS_RATIO_W-1:0] ratioOut,
  input wire logic                    ratioOe,
  input wire logic                    coreReady
);
  logic [15:0] pgLowCnt;
  logic [15:0] rstCnt;
  logic [15:0] strapCnt;

  // Counts low power-good, held reset and unchanged driven straps.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pgLowCnt <= '0;
      rstCnt   <= '0;
      strapCnt <= '0;
    end else begin
      pgLowCnt <= powerOk ? '0 : pgLowCnt + 16'h1;
      rstCnt   <= (powerOk && !hardReset_n) ? rstCnt + 16'h1 : '0;
      strapCnt <= !(cfgOe && ratioOe) ? '0 :
                  ($changed(cfgOut) || $changed(ratioOut)) ? 16'h1 : strapCnt + 16'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence released_s;
    $rose(hardReset_n);
  endsequence
  sequence straps_held_s;
    (cfgOe && ratioOe && $stable(cfgOut) && $stable(ratioOut))[*2];
  endsequence

  pg_low_a: assert property ($rose(powerOk) |-> pgLowCnt >= `RCS_PG_LOW_CYCLES)
    else $error("power good rose too soon");
  reset_len_a: assert property (released_s |-> rstCnt >= RST_CYCLES)
    else $error("hard reset released too soon");
  cfg_setup_a: assert property (released_s |-> strapCnt >= `RCS_CFG_SETUP)
    else $error("straps not set up before release");
  ratio_setup_a: assert property (released_s |-> strapCnt >= RST_CYCLES)
    else $error("ratio straps not set up long enough");
  strap_hold_a: assert property (released_s |-> straps_held_s ##[0:19] !cfgOe && !ratioOe)
    else $error("strap hold outside its window");
  safe_ratio_a: assert property ($fell(hardReset_n) && powerOk |-> ##[0:4] ratioOe)
    else $error("ratio straps not driven after reset");
  reset_width_a: assert property ($changed(hardReset_n) |=> $stable(hardReset_n))
    else $error("hard reset level too short");
  ready_width_a: assert property ($changed(coreReady) |=> $stable(coreReady))
    else $error("ready level too short");
  ready_late_a: assert property (released_s |-> ##[1:8] coreReady)
    else $error("device not ready after release");
  ready_drop_a: assert property ($fell(hardReset_n) |-> ##[1:6] !coreReady)
    else $error("device ready kept during reset");
endmodule : reset_config_sequencer_sva

//--- tb/reset_config_sequencer_tb.sv
`timescale 1ns/1ps
`include "rcs_consts.svh"

module reset_config_sequencer_tb;
  import rcs_pkg::*;
  localparam int RSTC  = 8;
  localparam int HOLDC = 10;

  logic                   mclk;
  logic                   rst_n;
  logic                   supplyOk;
  logic                   warmReq;
  cfg_t                   cfgValue;
  logic                   ratioFive;
  logic                   inReset;
  logic                   sysRunning;
  logic                   coreSeen;
  logic [`RCS_MULT_W-1:0] coreMult;
  logic [`RCS_MULT_W-1:0] coreMult2;
  cfg_t                   cfgStraps;
  logic                   devRunning;
  logic [3:0]             flags;
  logic [3:0]             flags2;
  logic [3:0]             flags3;
  logic [31:0]            seed;
  int                     errors;
  int                     checksDone;
  int                     expQ[$];

  rcs_if link();
  rcs_if link2();
  rcs_if link3();

  rcs_system #(.RST_CYCLES(RSTC), .HOLD_CYCLES(HOLDC)) rcs_system_i (
    .mclk(mclk), .rst_n(rst_n), .link(link), .supplyOk(supplyOk), .warmReq(warmReq),
    .cfgValue(cfgValue), .ratioFive(ratioFive), .inReset(inReset), .running(sysRunning),
    .coreReadySeen(coreSeen));
  rcs_device #(.RST_CYCLES(RSTC)) rcs_device_i (
    .mclk(mclk), .rst_n(rst_n), .link(link), .coreMult(coreMult), .cfgStraps(cfgStraps),
    .running(devRunning), .ratioErr(flags[0]), .powerLowShort(flags[1]),
    .resetShort(flags[2]), .pulseShort(flags[3]));
  // Second device faces a driver that breaks the system-side timing on purpose.
  rcs_device #(.RST_CYCLES(RSTC)) rcs_device_i2 (
    .mclk(mclk), .rst_n(rst_n), .link(link2), .coreMult(coreMult2), .cfgStraps(),
    .running(), .ratioErr(flags2[0]), .powerLowShort(flags2[1]),
    .resetShort(flags2[2]), .pulseShort(flags2[3]));
  // Third device sees the same broken timing but is told its clock starts fast.
  rcs_device #(.RST_CYCLES(RSTC), .FAST_CLK_START(1'b1)) rcs_device_i3 (
    .mclk(mclk), .rst_n(rst_n), .link(link3), .coreMult(), .cfgStraps(),
    .running(), .ratioErr(flags3[0]), .powerLowShort(flags3[1]),
    .resetShort(flags3[2]), .pulseShort(flags3[3]));
  reset_config_sequencer_sva #(.RST_CYCLES(RSTC)) reset_config_sequencer_sva_i (
    .mclk(mclk), .rst_n(rst_n), .powerOk(link.powerOk), .hardReset_n(link.hardReset_n),
    .cfgOut(link.cfgOut), .cfgOe(link.cfgOe), .ratioOut(link.ratioOut),
    .ratioOe(link.ratioOe), .coreReady(link.coreReady));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  // Drives both rule-breaking links alike, then waits n clocks.
  task automatic drive2(input logic pg, input logic rstN, input int n);
    link2.powerOk     = pg;
    link2.hardReset_n = rstN;
    link3.powerOk     = pg;
    link3.hardReset_n = rstN;
    tick(n);
  endtask : drive2

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic closeOut();
    $display("errors %0d checks %0d", errors, checksDone);
    if (errors == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : closeOut

  // One cold or warm start, measured against the model queue.
  task automatic boot(input bit warm, input bit five);
    int n;
    int m;
    seed = xs(seed);
    cfgValue = seed[14:0];
    ratioFive = five;
    expQ.push_back({five, cfgValue});
    tick(1);
    if (warm) warmReq = 1'b1;
    else supplyOk = 1'b1;
    tick(1);
    warmReq = 1'b0;
    // The system sees both user inputs two flops late.
    tick(2);
    n = 0;
    while (link.powerOk !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    if (!warm) chk(n, `RCS_PG_LOW_CYCLES);
    else chk({link.hardReset_n, link.cfgOe}, 2'h1);
    m = 0;
    while (link.hardReset_n !== 1'b1 && m < 100) begin
      tick(1);
      m++;
    end
    chk(m, RSTC);
    n = 0;
    while (link.cfgOe !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    chk(n, HOLDC);
    n = 0;
    while (devRunning !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    tick(3);
    m = expQ.pop_front();
    chk(coreMult, m[15] ? `RCS_MULT_X5 : `RCS_MULT_X4);
    chk(cfgStraps, m[14:0]);
    chk({sysRunning, coreSeen, flags}, 6'h30);
  endtask : boot

  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    closeOut();
  end

  initial begin
    rst_n = 1'b0;
    supplyOk = 1'b0;
    warmReq = 1'b0;
    cfgValue = '0;
    ratioFive = 1'b0;
    seed = 32'h3B15;
    errors = 0;
    checksDone = 0;
    link2.powerOk = 1'b0;
    link2.hardReset_n = 1'b0;
    link2.cfgOut = '0;
    link2.cfgOe = 1'b1;
    link2.ratioOut = 4'h7;
    link2.ratioOe = 1'b1;
    link3.powerOk = 1'b0;
    link3.hardReset_n = 1'b0;
    link3.cfgOut = '0;
    link3.cfgOe = 1'b1;
    link3.ratioOut = 4'h7;
    link3.ratioOe = 1'b1;
    tick(16);
    rst_n = 1'b1;
    chk({sysRunning, devRunning, coreMult}, 5'h04);
    boot(1'b0, 1'b0);
    boot(1'b1, 1'b1);
    boot(1'b1, 1'b0);
    supplyOk = 1'b0;
    tick(3);
    chk({link.powerOk, inReset}, 2'h1);
    tick(12);
    boot(1'b0, 1'b1);
    supplyOk = 1'b0;
    rst_n = 1'b0;
    tick(2);
    chk({sysRunning, devRunning, coreMult}, 5'h04);
    rst_n = 1'b1;
    tick(2);
    boot(1'b0, 1'b0);
    drive2(1'b1, 1'b0, 4);
    drive2(1'b0, 1'b0, 3);
    drive2(1'b1, 1'b0, 3);
    drive2(1'b1, 1'b1, 4);
    drive2(1'b1, 1'b0, 1);
    drive2(1'b1, 1'b1, 8);
    chk({flags2, coreMult2}, {4'hF, `RCS_MULT_X4});
    chk(flags3, 4'hD);
    closeOut();
  end
endmodule : reset_config_sequencer_tb
